// file: spi_flash_cmd.sv
// Purpose: Serial flash command interpreter for read-modify-write,
//          battery test, status read/write and parameter-table read
// Assumes: Serial pins sampled by ref_clk; link clock well below ref_clk/4
// Notes:   Data out changes a few ref_clk cycles after the sampling edge
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Unaligned release of monitor command means standby
// - After power-up the device sits in standby
// - Read-modify-write is opcode then 24 address bits
// - Address: page from 21:8, start byte 7:0
// - Up to 256 data bytes, buffer pointer wraps
// - Chip-select rise programs only the received bytes
// - Unaligned chip-select rise cancels read-modify-write
// - Busy flag set while reprogramming runs
// - Battery command is a lone eight-bit opcode
// - Battery test starts at release, fixed duration, params unused
// - Monitor drives busy flag on output each cycle
// - Status read with address returns that register
// - Result field 10 above threshold, 11 below
// - Holds a 256-byte table read by 5Ah
// - Table read: opcode, address, dummy, then data
// - Release ends table read, output goes idle
// - Table address wraps from FFh to 00h
// - Monitor needs a dummy byte only in mode 3
module spi_flash_cmd
	import spi_flash_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        sck,
	input  wire logic        csN,
	input  wire logic        si,
	input  wire logic        battLow,
	input  wire logic        tblWrEn,
	input  wire logic [7:0]  tblWrAddr,
	input  wire logic [7:0]  tblWrData,
	input  wire logic        arrayWrReady,
	output logic             so,
	output logic             soOe,
	output logic             busy,
	output logic             arrayWrValid,
	output logic      [21:0] arrayWrAddr,
	output logic      [7:0]  arrayWrData
);

	logic [3:0]    inMeta;
	logic [3:0]    inSync;
	logic          sckPrev;
	logic          csPrev;
	logic          sckS;
	logic          csS;
	logic          siS;
	logic          battS;
	logic          sckRise;
	logic          csFall;
	logic          csRise;
	logic [6:0]    shiftIn;
	logic [7:0]    byteVal;
	logic [2:0]    bitInByte;
	logic [9:0]    byteCnt;
	logic          byteDone;
	logic [7:0]    opcode;
	logic [23:0]   addrReg;
	logic [7:0]    wrPtr;
	logic [255:0]  mask;
	logic [7:0]    stAddr;
	logic [7:0]    tblAddr;
	logic [7:0]    tblData;
	logic          mode3Reg;
	logic          pbWrEn;
	logic [7:0]    pbRdData;
	engine_state_t engState;
	logic [7:0]    scanIdx;
	logic [13:0]   engPage;
	logic [15:0]   timer;
	logic          write_enable_latch;
	logic [5:0]    sr6Params;
	logic [1:0]    sr6Result;
	logic [7:0]    sr1Byte;
	logic [7:0]    sr6Byte;
	logic [7:0]    curByte;
	logic          aligned;
	logic          rmwGo;
	logic          battGo;
	logic          welGo;
	logic          monPhase;
	logic          outPhase;
	logic [29:0]   fifoE0;
	logic [29:0]   fifoE1;
	logic [1:0]    fifoCount;
	logic [1:0]    fifoCountNext;
	logic          fifoInReady;
	logic          push;
	logic          pop;
	logic [29:0]   pushWord;

	// Two-stage synchronisers for sck, csN, si and battLow; csN idles high
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			inMeta  <= 4'h4;
			inSync  <= 4'h4;
			sckPrev <= 1'b0;
			csPrev  <= 1'b1;
		end
		else
		begin
			inMeta  <= {sck, csN, si, battLow};
			inSync  <= inMeta;
			sckPrev <= inSync[3];
			csPrev  <= inSync[2];
		end
	end

	// Edges are found on the second stage only
	assign sckS     = inSync[3];
	assign csS      = inSync[2];
	assign siS      = inSync[1];
	assign battS    = inSync[0];
	assign sckRise  = sckS & ~sckPrev & ~csS;
	assign csFall   = ~csS & csPrev;
	assign csRise   = csS & ~csPrev;
	assign byteVal  = {shiftIn, siS};
	assign byteDone = sckRise & (bitInByte == 3'h7);
	assign aligned  = (bitInByte == 3'h0);

	// Bit and byte counting, opcode and address capture (MSB first)
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			shiftIn   <= 7'h00;
			bitInByte <= 3'h0;
			byteCnt   <= 10'h000;
			opcode    <= 8'h00;
			addrReg   <= 24'h000000;
			mode3Reg  <= 1'b0;
		end
		else if (csFall)
		begin
			bitInByte <= 3'h0;
			byteCnt   <= 10'h000;
			mode3Reg  <= sckS; // Clock idling high at select means mode 3
		end
		else if (sckRise)
		begin
			shiftIn   <= byteVal[6:0];
			bitInByte <= bitInByte + 3'h1;
			if (byteDone && byteCnt != BYTE_CNT_MAX)
				byteCnt <= byteCnt + 10'h001;
			if (byteDone && byteCnt == 10'h000)
				opcode <= byteVal;
			if (byteDone && byteCnt != 10'h000 && byteCnt <= BYTE_ADDR_LAST)
				addrReg <= {addrReg[15:0], byteVal};
		end
	end

	// Page buffer fill; frozen while the engine is busy
	assign pbWrEn = byteDone & (opcode == OP_RMW) & ~busy
		& (byteCnt >= BYTE_RMW_DATA);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			mask  <= '0;
			wrPtr <= 8'h00;
		end
		else if (csFall && !busy)
			mask <= '0;
		else if (byteDone && opcode == OP_RMW && !busy)
		begin
			if (byteCnt == BYTE_ADDR_LAST)
				wrPtr <= byteVal;
			else if (byteCnt >= BYTE_RMW_DATA)
			begin
				mask[wrPtr] <= 1'b1;
				wrPtr       <= wrPtr + 8'h01;
			end
		end
	end

	// Table address and status-register address capture
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			tblAddr <= 8'h00;
			stAddr  <= 8'h00;
		end
		else if (byteDone)
		begin
			if (opcode == OP_PARAM_RD && byteCnt == BYTE_ADDR_LAST)
				tblAddr <= byteVal;
			else if (opcode == OP_PARAM_RD && byteCnt >= BYTE_PARAM_DATA)
				tblAddr <= tblAddr + 8'h01;
			if ((opcode == OP_STATUS_RD || opcode == OP_STATUS_WR)
				&& byteCnt == BYTE_STATUS_ADDR)
				stAddr <= byteVal;
		end
	end

	// Release decoding: only whole-byte frames start anything
	assign welGo  = (opcode == OP_WRITE_ENABLE) & aligned
		& (byteCnt == BYTE_OPCODE_DONE);
	assign rmwGo  = (opcode == OP_RMW) & aligned & write_enable_latch
		& (byteCnt >= BYTE_RMW_MIN);
	assign battGo = (opcode == OP_BATTERY) & aligned
		& (byteCnt == BYTE_OPCODE_DONE);

	// Self-timed engine: drain marked bytes, program time, battery test
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			engState  <= ENG_IDLE;
			busy      <= 1'b0;
			scanIdx   <= 8'h00;
			engPage   <= 14'h0000;
			timer     <= 16'h0000;
			write_enable_latch       <= 1'b0;
			sr6Params <= SR6_PARAM_RST;
			sr6Result <= SR6_RES_RST;
		end
		else
		begin
			if (byteDone && opcode == OP_STATUS_WR && stAddr == SR6_ADDR
				&& byteCnt == BYTE_STATUS_DATA)
				sr6Params <= byteVal[5:0];
			case (engState)
				ENG_IDLE:
				begin
					if (csRise && welGo)
						write_enable_latch <= 1'b1;
					else if (csRise && rmwGo)
					begin
						engState <= ENG_READ;
						busy     <= 1'b1;
						scanIdx  <= 8'h00;
						engPage  <= addrReg[21:8];
						write_enable_latch      <= 1'b0;
					end
					else if (csRise && battGo)
					begin
						engState <= ENG_BATT;
						busy     <= 1'b1;
						timer    <= BATT_CYCLES - 16'h0001;
					end
				end
				ENG_READ:
				begin
					// Unmarked bytes are skipped, so the page keeps them
					if (mask[scanIdx])
						engState <= ENG_WAIT;
					else if (scanIdx == LAST_PAGE_BYTE)
					begin
						engState <= ENG_PROG;
						timer    <= PROG_CYCLES - 16'h0001;
					end
					else
						scanIdx <= scanIdx + 8'h01;
				end
				ENG_WAIT:
					engState <= ENG_PUSH;
				ENG_PUSH:
				begin
					if (fifoInReady && scanIdx == LAST_PAGE_BYTE)
					begin
						engState <= ENG_PROG;
						timer    <= PROG_CYCLES - 16'h0001;
					end
					else if (fifoInReady)
					begin
						engState <= ENG_READ;
						scanIdx  <= scanIdx + 8'h01;
					end
				end
				ENG_PROG:
				begin
					// Busy holds until time is up and the array took all
					if (timer != 16'h0000)
						timer <= timer - 16'h0001;
					else if (fifoCount == 2'h0)
					begin
						engState <= ENG_IDLE;
						busy     <= 1'b0;
					end
				end
				ENG_BATT:
				begin
					if (timer != 16'h0000)
						timer <= timer - 16'h0001;
					else
					begin
						sr6Result <= battS ? RESULT_BELOW : RESULT_ABOVE;
						engState  <= ENG_IDLE;
						busy      <= 1'b0;
					end
				end
				default:
				begin
					engState <= ENG_IDLE;
					busy     <= 1'b0;
				end
			endcase
		end
	end

	// Two-entry buffer toward the array; a stall holds the engine in PUSH
	assign fifoInReady = (fifoCount != 2'h2);
	assign push        = (engState == ENG_PUSH) & fifoInReady;
	assign pop         = arrayWrValid & arrayWrReady;
	assign pushWord    = {engPage, scanIdx, pbRdData};
	assign fifoCountNext = fifoCount + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			fifoE0       <= 30'h00000000;
			fifoE1       <= 30'h00000000;
			fifoCount    <= 2'h0;
			arrayWrValid <= 1'b0;
		end
		else
		begin
			fifoCount    <= fifoCountNext;
			arrayWrValid <= (fifoCountNext != 2'h0);
			if (pop)
				fifoE0 <= (fifoCount == 2'h1) ? pushWord : fifoE1;
			else if (push && fifoCount == 2'h0)
				fifoE0 <= pushWord;
			if (push && (fifoCount - {1'b0, pop}) == 2'h1)
				fifoE1 <= pushWord;
		end
	end

	assign arrayWrAddr = fifoE0[29:8];
	assign arrayWrData = fifoE0[7:0];

	// Page buffer: written from the link, read by the engine
	spi_byte_ram pageBuf (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wrEn    (pbWrEn),
		.wrAddr  (wrPtr),
		.wrData  (byteVal),
		.rdAddr  (scanIdx),
		.rdData  (pbRdData)
	);

	// Parameter table, loaded through the factory port
	spi_byte_ram paramTbl (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wrEn    (tblWrEn),
		.wrAddr  (tblWrAddr),
		.wrData  (tblWrData),
		.rdAddr  (tblAddr),
		.rdData  (tblData)
	);

	// Output phase decode and byte selection
	assign sr1Byte  = {6'h00, write_enable_latch, busy};
	assign sr6Byte  = {sr6Result, sr6Params};
	assign monPhase = (opcode == OP_MONITOR) & (byteCnt >=
		(mode3Reg ? BYTE_MON_MODE3 : BYTE_MON_MODE0));
	assign outPhase = monPhase
		| ((opcode == OP_PARAM_RD) & (byteCnt >= BYTE_PARAM_DATA))
		| ((opcode == OP_STATUS_RD) & (byteCnt >= BYTE_STATUS_OUT));

	always_comb
	begin
		if (opcode == OP_PARAM_RD)
			curByte = tblData;
		else if (stAddr == SR1_ADDR)
			curByte = sr1Byte;
		else if (stAddr == SR6_ADDR)
			curByte = sr6Byte;
		else
			curByte = 8'h00;
	end

	// Serial output: released three ref_clk cycles after select goes high
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			so   <= 1'b0;
			soOe <= 1'b0;
		end
		else
		begin
			soOe <= outPhase & ~csS;
			if (monPhase)
				so <= busy;
			else
				so <= curByte[~bitInByte];
		end
	end

endmodule
`default_nettype wire

// file: spi_flash_pkg.sv
// Purpose: Shared constants for the serial flash command interpreter
// Assumes: 100 MHz ref_clk, serial link sampled in the ref_clk domain
// Notes:   Opcodes, status layout, frame byte positions, self-timed counts
package spi_flash_pkg;

	// Opcodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_RMW          = 8'h0a;
	localparam logic [7:0] OP_BATTERY      = 8'hef;
	localparam logic [7:0] OP_STATUS_RD    = 8'h65;
	localparam logic [7:0] OP_STATUS_WR    = 8'h71;
	localparam logic [7:0] OP_MONITOR      = 8'h25;
	localparam logic [7:0] OP_PARAM_RD     = 8'h5a;

	// Status register addresses
	localparam logic [7:0] SR1_ADDR = 8'h01;
	localparam logic [7:0] SR6_ADDR = 8'h06;

	// Status field positions and values
	localparam int         SR1_BUSY_BIT  = 0;
	localparam int         SR1_WEL_BIT   = 1;
	localparam logic [1:0] RESULT_ABOVE  = 2'b10;
	localparam logic [1:0] RESULT_BELOW  = 2'b11;
	localparam logic [5:0] SR6_PARAM_RST = 6'h00;
	localparam logic [1:0] SR6_RES_RST   = 2'h0;

	// Byte positions within a frame (byte 0 is the opcode)
	localparam logic [9:0] BYTE_OPCODE_DONE = 10'h001;
	localparam logic [9:0] BYTE_ADDR_LAST   = 10'h003;
	localparam logic [9:0] BYTE_RMW_DATA    = 10'h004;
	localparam logic [9:0] BYTE_RMW_MIN     = 10'h005;
	localparam logic [9:0] BYTE_PARAM_DATA  = 10'h005;
	localparam logic [9:0] BYTE_STATUS_ADDR = 10'h001;
	localparam logic [9:0] BYTE_STATUS_OUT  = 10'h002;
	localparam logic [9:0] BYTE_STATUS_DATA = 10'h002;
	localparam logic [9:0] BYTE_MON_MODE0   = 10'h001;
	localparam logic [9:0] BYTE_MON_MODE3   = 10'h002;
	localparam logic [9:0] BYTE_CNT_MAX     = 10'h3ff;
	localparam logic [7:0] LAST_PAGE_BYTE   = 8'hff;

	// Self-timed operation lengths
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS  = 2000;
	localparam int BATT_TIME_NS  = 5000;
	localparam logic [15:0] PROG_CYCLES =
		16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] BATT_CYCLES =
		16'((BATT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Internal engine states
	typedef enum logic [2:0]
	{
		ENG_IDLE = 3'b000,
		ENG_READ = 3'b001,
		ENG_WAIT = 3'b010,
		ENG_PUSH = 3'b011,
		ENG_PROG = 3'b100,
		ENG_BATT = 3'b101
	} engine_state_t;

endpackage

// file: spi_byte_ram.sv
// Purpose: 256 x 8 memory with one write port and a registered read port
// Assumes: Single clock, write and read addresses independent
// Notes:   Used for the page buffer and for the parameter table
`timescale 1ns/100ps
`default_nettype none

module spi_byte_ram (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrAddr,
	input  wire logic [7:0] wrData,
	input  wire logic [7:0] rdAddr,
	output logic      [7:0] rdData
);

	logic [7:0] mem [0:255];

	// Storage has no reset; contents are defined by writes only
	always_ff @(posedge ref_clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end

	// Registered read, one cycle of latency
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rdData <= 8'h00;
		else
			rdData <= mem[rdAddr];
	end

endmodule
`default_nettype wire

// file: spi_flash_cmd_props.sv
// Purpose: Port-level checks for the serial flash command interpreter
// Assumes: Host keeps chip select high at least 8 ref_clk between frames
// Notes:   Sees only the top ports; attached by the bind at the foot
`timescale 1ns/100ps
`default_nettype none

module spi_flash_cmd_props (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        csN,
	input  wire logic        soOe,
	input  wire logic        busy,
	input  wire logic        arrayWrValid,
	input  wire logic        arrayWrReady,
	input  wire logic [21:0] arrayWrAddr,
	input  wire logic [7:0]  arrayWrData
);
	// One domain, so one clock and one disable for all checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Standby right after reset release
	a_reset_standby: assert property (
		$rose(rst_n) |-> !busy && !soOe && !arrayWrValid)
		else $error("outputs not quiet after reset");
	// A stalled word must not be lost or altered
	a_word_held: assert property (
		arrayWrValid && !arrayWrReady |=> arrayWrValid
		&& $stable(arrayWrAddr) && $stable(arrayWrData))
		else $error("array word changed while stalled");
	a_word_busy: assert property (
		arrayWrValid |-> busy)
		else $error("array word without busy");
	a_busy_min: assert property (
		$rose(busy) |-> busy [*8])
		else $error("busy dropped too early");
	a_drain_first: assert property (
		$fell(busy) |-> !arrayWrValid)
		else $error("busy cleared with a word pending");
	// Self-timed work starts only after a release
	a_start_release: assert property (
		$rose(busy) |-> $past(csN, 2))
		else $error("busy rose while selected");
	a_oe_drop: assert property (
		$rose(csN) |-> ##[1:6] !soOe)
		else $error("output not released after deselect");
	a_oe_idle: assert property (
		csN [*6] |-> !soOe)
		else $error("output driven while deselected");
endmodule

bind spi_flash_cmd spi_flash_cmd_props spi_flash_cmd_props_i (
	.ref_clk      (ref_clk),
	.rst_n        (rst_n),
	.csN          (csN),
	.soOe         (soOe),
	.busy         (busy),
	.arrayWrValid (arrayWrValid),
	.arrayWrReady (arrayWrReady),
	.arrayWrAddr  (arrayWrAddr),
	.arrayWrData  (arrayWrData)
);
`default_nettype wire

// file: spi_host_model.sv
// Purpose: Host controller model driving the serial link in mode 0 or 3
// Assumes: ref_clk 100 MHz; serial clock about 125 ns, idle between frames
// Notes:   Off output reads as a changing value, never the last bit
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
	input  wire logic ref_clk,
	input  wire logic so,
	input  wire logic soOe,
	output var  logic sck,
	output var  logic csN,
	output var  logic si
);
	int   halfCnt;
	logic mode3;

	// Idle: deselected, clock low
	initial
	begin
		sck = 1'b0;
		csN = 1'b1;
		si = 1'b0;
		halfCnt = 0;
		mode3 = 1'b0;
	end

	task automatic waitClk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Clock level at select picks the mode: low for 0, high for 3
	task automatic open(input logic m3);
		waitClk(1);
		mode3 = m3;
		sck <= m3;
		waitClk(3);
		csN <= 1'b0;
		waitClk(4);
	endtask

	// Clock back to its idle level; released data line is inverted
	task automatic close();
		sck <= mode3;
		waitClk(4);
		csN <= 1'b1;
		si <= ~si;
		waitClk(10);
	endtask

	// MSB first; each bit opens with a fall, so back-to-back calls
	// never write the clock twice in one time step
	task automatic shift(input logic [7:0] tx, input int n,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			sck <= 1'b0;
			si <= tx[i];
			waitClk(6 + halfCnt % 2);
			halfCnt++;
			sck <= 1'b1;
			rx[i] = soOe ? so : halfCnt[0];
			waitClk(6);
		end
	endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the serial flash command interpreter
// Assumes: Host model on the link, bench drives the array and table ports
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/100ps
`default_nettype none

module testbench
	import spi_flash_pkg::*;
;
	logic             ref_clk = 1'b0;
	logic             rst_n = 1'b0;
	logic             battLow = 1'b0;
	logic             tblWrEn = 1'b0;
	logic      [7:0]  tblWrAddr = 8'h00;
	logic      [7:0]  tblWrData = 8'h00;
	logic             arrayWrReady = 1'b0;
	wire logic        sck, csN, si, so, soOe, busy, arrayWrValid;
	wire logic [21:0] arrayWrAddr;
	wire logic [7:0]  arrayWrData;
	logic      [7:0]  rx;
	int               numErrors = 0;
	int               cmpCount = 0;

	always #5 ref_clk = ~ref_clk;

	spi_flash_cmd spi_flash_cmd_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.sck(sck), .csN(csN), .si(si), .battLow(battLow),
		.tblWrEn(tblWrEn), .tblWrAddr(tblWrAddr), .tblWrData(tblWrData),
		.arrayWrReady(arrayWrReady), .so(so), .soOe(soOe), .busy(busy),
		.arrayWrValid(arrayWrValid), .arrayWrAddr(arrayWrAddr),
		.arrayWrData(arrayWrData));
	spi_host_model spi_host_model_i (.ref_clk(ref_clk), .so(so),
		.soOe(soOe), .sck(sck), .csN(csN), .si(si));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (numErrors == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Sends n whole bytes, the top used byte of b first
	task automatic sendBytes(input logic [63:0] b, input int n);
		for (int i = n - 1; i >= 0; i--)
			spi_host_model_i.shift(b[8*i +: 8], 8, rx);
	endtask

	// Whole-byte mode 0 frame; last byte received stays in rx
	task automatic frame(input logic [63:0] b, input int n);
		spi_host_model_i.open(1'b0);
		sendBytes(b, n);
		spi_host_model_i.close();
	endtask

	task automatic statusIs(input logic [7:0] a, input logic [7:0] exp);
		frame(64'({OP_STATUS_RD, a, 8'h00}), 3);
		check(rx, exp);
	endtask

	// Bounded wait; running out ends the run
	task automatic waitBusy(input logic lvl);
		int n = 0;
		while (busy !== lvl && n < 3000)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(busy, lvl);
		if (n == 3000)
			tally_and_finish();
	endtask

	task automatic s_reset();
		check({busy, soOe, arrayWrValid}, 3'b000);
		statusIs(SR6_ADDR, 8'h00);
		statusIs(SR1_ADDR, 8'h00);
	endtask

	// Without write enable, then cut short mid-byte: nothing starts
	task automatic s_rmw_refused();
		frame(64'({OP_RMW, 8'h00, 8'h01, 8'h00, 8'h55}), 5);
		repeat (20) @(posedge ref_clk);
		check(busy, 1'b0);
		frame(64'(OP_WRITE_ENABLE), 1);
		statusIs(SR1_ADDR, 8'h02);
		spi_host_model_i.open(1'b0);
		sendBytes(64'({OP_RMW, 8'h00, 8'h01, 8'h00, 8'h55}), 5);
		spi_host_model_i.shift(8'haa, 3, rx);
		spi_host_model_i.close();
		repeat (20) @(posedge ref_clk);
		check({busy, arrayWrValid}, 2'b00);
	endtask

	// Start near page end so the buffer wraps; array stalls a third
	task automatic s_rmw();
		logic [29:0] got [$];
		int n = 0;
		frame(64'(OP_WRITE_ENABLE), 1);
		frame(64'({OP_RMW, 8'hc0, 8'h12, 8'hfe, 8'hd0, 8'hd1, 8'hd2}), 7);
		waitBusy(1'b1);
		while (busy === 1'b1 && n < 3000)
		begin
			@(negedge ref_clk);
			if (arrayWrValid === 1'b1 && arrayWrReady === 1'b1)
				got.push_back({arrayWrAddr, arrayWrData});
			@(posedge ref_clk);
			arrayWrReady <= (n % 3 != 0);
			n++;
		end
		check(busy, 1'b0);
		if (n == 3000)
			tally_and_finish();
		check(got.size(), 32'd3);
		check(got[0], {14'h0012, 8'h00, 8'hd2});
		check(got[1], {14'h0012, 8'hfe, 8'hd0});
		check(got[2], {14'h0012, 8'hff, 8'hd1});
	endtask

	task automatic s_battery();
		int n = 0;
		battLow <= 1'b1;
		frame(64'({OP_STATUS_WR, SR6_ADDR, 8'h2a}), 3);
		statusIs(SR6_ADDR, 8'h2a);
		frame(64'(OP_BATTERY), 1);
		spi_host_model_i.open(1'b0);
		spi_host_model_i.shift(OP_MONITOR, 8, rx);
		@(negedge ref_clk);
		check({soOe, so}, 2'b11);
		while (so === 1'b1 && n < 1000)
		begin
			@(negedge ref_clk);
			n++;
		end
		check({soOe, so, busy}, 3'b100);
		if (n == 1000)
			tally_and_finish();
		// Monitor cut mid-byte: output released, later commands still work
		@(posedge ref_clk);
		spi_host_model_i.shift(8'h00, 3, rx);
		spi_host_model_i.close();
		check(soOe, 1'b0);
		statusIs(SR6_ADDR, {RESULT_BELOW, 6'h2a});
		battLow <= 1'b0;
		frame(64'(OP_BATTERY), 1);
		waitBusy(1'b1);
		// Mode 3 monitor drives nothing until the dummy byte is in
		spi_host_model_i.open(1'b1);
		spi_host_model_i.shift(OP_MONITOR, 8, rx);
		check(soOe, 1'b0);
		spi_host_model_i.shift(8'h00, 8, rx);
		@(negedge ref_clk);
		check({soOe, so}, 2'b11);
		@(posedge ref_clk);
		spi_host_model_i.close();
		waitBusy(1'b0);
		statusIs(SR6_ADDR, {RESULT_ABOVE, 6'h2a});
		spi_host_model_i.open(1'b0);
		spi_host_model_i.shift(OP_BATTERY, 8, rx);
		spi_host_model_i.shift(8'h00, 3, rx);
		spi_host_model_i.close();
		repeat (20) @(posedge ref_clk);
		check(busy, 1'b0);
	endtask

	// Table read across the top address, then release mid-byte
	task automatic s_table();
		for (int i = 0; i < 256; i++)
		begin
			@(posedge ref_clk);
			tblWrEn <= 1'b1;
			tblWrAddr <= 8'(i);
			tblWrData <= 8'(i) ^ 8'h3c;
		end
		@(posedge ref_clk);
		tblWrEn <= 1'b0;
		frame(64'({OP_PARAM_RD, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h00}), 6);
		check(rx, 8'hfe ^ 8'h3c);
		spi_host_model_i.open(1'b0);
		sendBytes(64'({OP_PARAM_RD, 8'h00, 8'h00, 8'hff, 8'h00}), 5);
		spi_host_model_i.shift(8'h00, 8, rx);
		check(rx, 8'hff ^ 8'h3c);
		spi_host_model_i.shift(8'h00, 8, rx);
		check(rx, 8'h00 ^ 8'h3c);
		spi_host_model_i.shift(8'h00, 3, rx);
		check(rx[7:5], 3'b001);
		spi_host_model_i.close();
		check(soOe, 1'b0);
	endtask

	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		s_reset();
		s_rmw_refused();
		s_rmw();
		s_battery();
		s_table();
		tally_and_finish();
	end
endmodule
`default_nettype wire
